// [core/sfs_pkg.sv]
package sfs_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_FLASH_UNLOCK = 8'hC9;
	localparam logic [7:0] IDX_T2_RELOAD_LO = 8'hCA;
	localparam logic [7:0] IDX_T2_RELOAD_HI = 8'hCB;
	localparam logic [7:0] IDX_T2_COUNT_LO = 8'hCC;
	localparam logic [7:0] IDX_T2_COUNT_HI = 8'hCD;
	localparam logic [7:0] IDX_EXTRA_ACC2 = 8'hCE;
	localparam logic [7:0] IDX_EXTRA_ACC3 = 8'hCF;
	localparam logic [7:0] IDX_STATUS_WORD = 8'hD0;
	localparam logic [7:0] IDX_PWM0_HI = 8'hD1;
	localparam logic [7:0] IDX_PWM0_LO = 8'hD2;
	localparam logic [7:0] IDX_PWM1_HI = 8'hD3;
	localparam logic [7:0] IDX_PWM1_LO = 8'hD4;
	localparam logic [7:0] IDX_PWM2_HI = 8'hD5;
	localparam logic [7:0] IDX_PWM2_LO = 8'hD6;
	localparam logic [7:0] IDX_CLOCK_CTRL = 8'hD8;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;

	// Field positions
	localparam int BIT_UNLOCK_ACTIVE = 7;
	localparam int BIT_TIMEOUT = 6;
	localparam int BIT_CARRY = 7;
	localparam int BIT_HALF_CARRY = 6;
	localparam int BIT_USER_FLAG_ZERO = 5;
	localparam int BIT_BANK_HIGH = 4;
	localparam int BIT_BANK_LOW = 3;
	localparam int BIT_SIGNED_RANGE = 2;
	localparam int BIT_USER_FLAG_ONE = 1;
	localparam int BIT_PARITY = 0;
	localparam int BIT_SLOW_OSC_KIND = 7;
	localparam int BIT_IRQ_TIMEOUT = 0;

	// Unlock codes of the flash write unlock register
	localparam logic [7:0] CODE_WRITE_LOW = 8'h4A;
	localparam logic [7:0] CODE_WRITE_HIGH = 8'h4C;
	localparam logic [7:0] CODE_ERASE_LOW = 8'hBA;
	localparam logic [7:0] CODE_ERASE_HIGH = 8'hBC;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_DUTY_HI_CH0 = 8'h80;
	localparam logic [7:0] RST_DUTY_HI_CH1 = 8'h80;
	localparam logic [7:0] RST_DUTY_HI_CH2 = 8'h80;
	localparam logic [7:0] RST_DUTY_LO = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam int PWM_CHANNELS = 3;
endpackage

// [core/sfs_regs.sv]
`timescale 1ns/10ps
// What this block does
// - Timeout sets read-only flag, unlock bit six
// - Flag clears while either unlock register zero
// - Timer2 reload bytes at CAh/CBh, reset 00h
// - Timer2 count bytes at CCh/CDh, reset 00h
// - Two extra accumulators CEh/CFh, reset 00h
// - Status word carry, half-carry, overflow, parity bits
// - Status word bank select and two user flags
// - Duty highs of channels 0-2 reset 80h
// - Channel 1 duty at D3h/D4h, same ordering
// - Channel 2 duty at D5h/D6h, same ordering
// - Slow oscillator kind writable only on fast clock
// - Kind 0 selects RC, 1 selects crystal
// - Non-code unlock write disables, clears timeout flag
module sfs_regs #(
	parameter int ADR_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic program_timeout_i,
	input wire logic [7:0] eeprom_write_unlock_i,
	input wire logic fast_clock_select_i,
	output logic flash_write_enable_o,
	output logic [15:0] timer2_reload_o,
	output logic [15:0] timer2_count_o,
	output logic [7:0] extra_accumulator_two_o,
	output logic [7:0] extra_accumulator_three_o,
	output logic [7:0] processor_status_word_o,
	output logic [47:0] pwm_duty_o,
	output logic slow_rc_osc_en_o,
	output logic slow_crystal_osc_en_o,
	output logic irq_o
);
	localparam int PWM_N = sfs_pkg::PWM_CHANNELS;
	logic access;
	logic wr;
	logic rd;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic [7:0] flash_write_unlock;
	logic unlock_active;
	logic program_timeout_flag;
	logic [7:0] timer2_reload_low;
	logic [7:0] timer2_reload_high;
	logic [7:0] timer2_count_low;
	logic [7:0] timer2_count_high;
	logic [7:0] extra_accumulator_two;
	logic [7:0] extra_accumulator_three;
	logic [7:0] processor_status_word;
	logic slow_osc_kind;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] duty_hi [PWM_N];
	logic [7:0] duty_lo [PWM_N];
	logic [7:0] lo_write_buf [PWM_N];
	logic [7:0] lo_read_latch [PWM_N];
	logic [7:0] next_rdata;
	logic adr_in_window;
	logic wr_flash_unlock;
	logic wr_t2_reload_lo;
	logic wr_t2_reload_hi;
	logic wr_t2_count_lo;
	logic wr_t2_count_hi;
	logic wr_extra_acc2;
	logic wr_extra_acc3;
	logic wr_status_word;
	logic wr_clock_ctrl;
	logic wr_irq_status;
	logic wr_irq_mask;

	// Request taken on the first cycle of a strobe; ack follows one edge later
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = access & wb_we_i & wb_sel_i[0];
	assign rd = access & ~wb_we_i;
	assign wbyte = wb_dat_i[7:0];

	// Only aligned addresses inside the first 1 KiB map; the rest decode to an unused index
	assign adr_in_window = (wb_adr_i[1:0] == 2'h0) && ((wb_adr_i >> 10) == '0);
	assign idx = adr_in_window ? wb_adr_i[9:2] : 8'hFF;

	// Per-register write strobes; a write with sel[0] low reaches none of them
	assign wr_flash_unlock = wr && (idx == sfs_pkg::IDX_FLASH_UNLOCK);
	assign wr_t2_reload_lo = wr && (idx == sfs_pkg::IDX_T2_RELOAD_LO);
	assign wr_t2_reload_hi = wr && (idx == sfs_pkg::IDX_T2_RELOAD_HI);
	assign wr_t2_count_lo = wr && (idx == sfs_pkg::IDX_T2_COUNT_LO);
	assign wr_t2_count_hi = wr && (idx == sfs_pkg::IDX_T2_COUNT_HI);
	assign wr_extra_acc2 = wr && (idx == sfs_pkg::IDX_EXTRA_ACC2);
	assign wr_extra_acc3 = wr && (idx == sfs_pkg::IDX_EXTRA_ACC3);
	assign wr_status_word = wr && (idx == sfs_pkg::IDX_STATUS_WORD);
	assign wr_clock_ctrl = wr && (idx == sfs_pkg::IDX_CLOCK_CTRL);
	assign wr_irq_status = wr && (idx == sfs_pkg::IDX_IRQ_STATUS);
	assign wr_irq_mask = wr && (idx == sfs_pkg::IDX_IRQ_MASK);

	// Single-cycle ack; unmapped indices still answer, reading zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= access;
		end
	end

	// Unlock is active only while a defined code is held
	always_comb begin
		unique case (flash_write_unlock)
			sfs_pkg::CODE_WRITE_LOW, sfs_pkg::CODE_WRITE_HIGH,
			sfs_pkg::CODE_ERASE_LOW, sfs_pkg::CODE_ERASE_HIGH: unlock_active = 1'b1;
			default: unlock_active = 1'b0;
		endcase
	end

	// Any byte is stored; only the defined codes make it an active unlock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_write_unlock <= sfs_pkg::RST_BYTE;
		end else if (wr_flash_unlock) begin
			flash_write_unlock <= wbyte;
		end
	end

	// Timeout flag: set wins so an event coinciding with a clear is kept
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			program_timeout_flag <= 1'b0;
		end else if (program_timeout_i) begin
			program_timeout_flag <= 1'b1;
		end else if (!unlock_active || eeprom_write_unlock_i == 8'h00) begin
			program_timeout_flag <= 1'b0;
		end
	end

	// Reload low byte; counting lives elsewhere, this only holds the software value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer2_reload_low <= sfs_pkg::RST_BYTE;
		end else if (wr_t2_reload_lo) begin
			timer2_reload_low <= wbyte;
		end
	end

	// Reload high byte; the pair is only coherent once both halves are written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer2_reload_high <= sfs_pkg::RST_BYTE;
		end else if (wr_t2_reload_hi) begin
			timer2_reload_high <= wbyte;
		end
	end

	// Count low byte as last written by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer2_count_low <= sfs_pkg::RST_BYTE;
		end else if (wr_t2_count_lo) begin
			timer2_count_low <= wbyte;
		end
	end

	// Count high byte; no arbitration against a running counter is done here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer2_count_high <= sfs_pkg::RST_BYTE;
		end else if (wr_t2_count_hi) begin
			timer2_count_high <= wbyte;
		end
	end

	// First extra accumulator, plain read/write byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			extra_accumulator_two <= sfs_pkg::RST_BYTE;
		end else if (wr_extra_acc2) begin
			extra_accumulator_two <= wbyte;
		end
	end

	// Second extra accumulator, plain read/write byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			extra_accumulator_three <= sfs_pkg::RST_BYTE;
		end else if (wr_extra_acc3) begin
			extra_accumulator_three <= wbyte;
		end
	end

	// Status word: flags, bank select and user flags are all writable as one byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			processor_status_word <= sfs_pkg::RST_BYTE;
		end else if (wr_status_word) begin
			processor_status_word <= wbyte;
		end
	end

	// Oscillator kind may only change while running from the fast clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_osc_kind <= 1'b0;
		end else if (wr_clock_ctrl && fast_clock_select_i) begin
			slow_osc_kind <= wbyte[sfs_pkg::BIT_SLOW_OSC_KIND];
		end
	end

	// Per-channel duty pair with write buffer and read latch for coherent 16-bit access
	genvar ch;
	generate
		for (ch = 0; ch < PWM_N; ch++) begin : g_pwm
			localparam logic [7:0] HI_IDX = 8'(sfs_pkg::IDX_PWM0_HI + 8'(2 * ch));
			localparam logic [7:0] LO_IDX = 8'(sfs_pkg::IDX_PWM0_LO + 8'(2 * ch));
			localparam logic [7:0] HI_RST = (ch == 0) ? sfs_pkg::RST_DUTY_HI_CH0 :
				(ch == 1) ? sfs_pkg::RST_DUTY_HI_CH1 : sfs_pkg::RST_DUTY_HI_CH2;
			// Low byte waits here until its high byte arrives
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					lo_write_buf[ch] <= sfs_pkg::RST_DUTY_LO;
				end else if (wr && idx == LO_IDX) begin
					lo_write_buf[ch] <= wbyte;
				end
			end
			// High write commits both halves at once, so the duty never shows a torn value
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					duty_hi[ch] <= HI_RST;
					duty_lo[ch] <= sfs_pkg::RST_DUTY_LO;
				end else if (wr && idx == HI_IDX) begin
					duty_hi[ch] <= wbyte;
					duty_lo[ch] <= lo_write_buf[ch];
				end
			end
			// High read freezes the low half for the read that follows
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					lo_read_latch[ch] <= sfs_pkg::RST_DUTY_LO;
				end else if (rd && idx == HI_IDX) begin
					lo_read_latch[ch] <= duty_lo[ch];
				end
			end
			// Committed duty for the waveform generator, registered once more
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pwm_duty_o[16*ch +: 16] <= {HI_RST, sfs_pkg::RST_DUTY_LO};
				end else begin
					pwm_duty_o[16*ch +: 16] <= {duty_hi[ch], duty_lo[ch]};
				end
			end
		end
	endgenerate

	// Mask is plain storage; it only gates the level output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= sfs_pkg::RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask <= wbyte;
		end
	end

	// Timeout event is sticky; writing one clears, but a new event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= sfs_pkg::RST_BYTE;
		end else begin
			irq_status[7:1] <= 7'h00; // Unused event bits read zero
			if (program_timeout_i) begin
				irq_status[sfs_pkg::BIT_IRQ_TIMEOUT] <= 1'b1;
			end else if (wr_irq_status && wbyte[sfs_pkg::BIT_IRQ_TIMEOUT]) begin
				irq_status[sfs_pkg::BIT_IRQ_TIMEOUT] <= 1'b0;
			end
		end
	end

	// Read mux; low duty reads come from the latch taken at the high read
	always_comb begin
		next_rdata = 8'h00;
		unique case (idx)
			sfs_pkg::IDX_FLASH_UNLOCK: begin
				next_rdata[sfs_pkg::BIT_UNLOCK_ACTIVE] = unlock_active;
				next_rdata[sfs_pkg::BIT_TIMEOUT] = program_timeout_flag;
			end
			sfs_pkg::IDX_T2_RELOAD_LO: next_rdata = timer2_reload_low;
			sfs_pkg::IDX_T2_RELOAD_HI: next_rdata = timer2_reload_high;
			sfs_pkg::IDX_T2_COUNT_LO: next_rdata = timer2_count_low;
			sfs_pkg::IDX_T2_COUNT_HI: next_rdata = timer2_count_high;
			sfs_pkg::IDX_EXTRA_ACC2: next_rdata = extra_accumulator_two;
			sfs_pkg::IDX_EXTRA_ACC3: next_rdata = extra_accumulator_three;
			sfs_pkg::IDX_STATUS_WORD: next_rdata = processor_status_word;
			sfs_pkg::IDX_PWM0_HI: next_rdata = duty_hi[0];
			sfs_pkg::IDX_PWM0_LO: next_rdata = lo_read_latch[0];
			sfs_pkg::IDX_PWM1_HI: next_rdata = duty_hi[1];
			sfs_pkg::IDX_PWM1_LO: next_rdata = lo_read_latch[1];
			sfs_pkg::IDX_PWM2_HI: next_rdata = duty_hi[2];
			sfs_pkg::IDX_PWM2_LO: next_rdata = lo_read_latch[2];
			sfs_pkg::IDX_CLOCK_CTRL: next_rdata[sfs_pkg::BIT_SLOW_OSC_KIND] = slow_osc_kind;
			sfs_pkg::IDX_IRQ_STATUS: next_rdata = irq_status;
			sfs_pkg::IDX_IRQ_MASK: next_rdata = irq_mask;
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data is captured at the taking edge and stands until the next read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			wb_dat_o <= {24'h00_0000, next_rdata};
		end
	end

	// Unlock state for the flash controller; registered so it never glitches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_write_enable_o <= 1'b0;
		end else begin
			flash_write_enable_o <= unlock_active;
		end
	end

	// Reload pair for the counter; one cycle behind the byte registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer2_reload_o <= {sfs_pkg::RST_BYTE, sfs_pkg::RST_BYTE};
		end else begin
			timer2_reload_o <= {timer2_reload_high, timer2_reload_low};
		end
	end

	// Count pair as software last left it; one cycle behind the byte registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer2_count_o <= {sfs_pkg::RST_BYTE, sfs_pkg::RST_BYTE};
		end else begin
			timer2_count_o <= {timer2_count_high, timer2_count_low};
		end
	end

	// Accumulator copies for the arithmetic unit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			extra_accumulator_two_o <= sfs_pkg::RST_BYTE;
			extra_accumulator_three_o <= sfs_pkg::RST_BYTE;
		end else begin
			extra_accumulator_two_o <= extra_accumulator_two;
			extra_accumulator_three_o <= extra_accumulator_three;
		end
	end

	// Status word copy; bank select reaches the register file one cycle late
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			processor_status_word_o <= sfs_pkg::RST_BYTE;
		end else begin
			processor_status_word_o <= processor_status_word;
		end
	end

	// Exactly one slow source enabled; the RC one is the safe choice out of reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_rc_osc_en_o <= 1'b1;
			slow_crystal_osc_en_o <= 1'b0;
		end else begin
			slow_rc_osc_en_o <= ~slow_osc_kind;
			slow_crystal_osc_en_o <= slow_osc_kind;
		end
	end

	// Level interrupt, high while any unmasked status bit stands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_mask);
		end
	end
endmodule

// [verification/sfs_regs_properties.sv]
`timescale 1ns/10ps
module sfs_regs_properties #(
	parameter int ADR_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic fast_clock_select_i,
	input wire logic flash_write_enable_o,
	input wire logic [47:0] pwm_duty_o,
	input wire logic slow_rc_osc_en_o,
	input wire logic slow_crystal_osc_en_o
);
	logic take_wr;
	logic duty_hi;
	logic unlock_adr;
	// Write taken at this edge; sel[0] gates the only data byte
	assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign duty_hi = wb_adr_i[1:0] == 2'h0 && wb_adr_i[9:2] inside {8'hD1, 8'hD3, 8'hD5};
	assign unlock_adr = wb_adr_i[9:0] == 10'h324;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_AFTER_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_READ_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_UNMAPPED_READ: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[1:0] != 2'h0
		|=> wb_dat_o == 32'h0) else $error("misaligned read not zero");
	AST_OSC_ONE_HOT: assert property (slow_rc_osc_en_o != slow_crystal_osc_en_o)
		else $error("oscillator enables not exclusive");
	// Two cycles of slow clock cover both possible output latencies
	AST_KIND_GUARD: assert property (!$past(fast_clock_select_i) && !$past(fast_clock_select_i, 2)
		|-> $stable(slow_crystal_osc_en_o)) else $error("oscillator kind changed on slow clock");
	AST_DUTY_COMMIT: assert property (!$stable(pwm_duty_o)
		|-> $past(take_wr && duty_hi) || $past(take_wr && duty_hi, 2)) else $error("duty changed without high write");
	AST_UNLOCK_CAUSE: assert property (!$stable(flash_write_enable_o)
		|-> $past(take_wr && unlock_adr) || $past(take_wr && unlock_adr, 2)) else $error("unlock changed without write");
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, program_timeout_i = 1'b0, fast_clock_select_i = 1'b1, flash_write_enable_o;
	logic slow_rc_osc_en_o, slow_crystal_osc_en_o, irq_o;
	logic [7:0] eeprom_write_unlock_i = 8'h01, rd, ea2, ea3, sw_out;
	logic [15:0] t2_reload, t2_count;
	logic [47:0] pwm_duty_o;
	logic [7:0] codes [4] = '{sfs_pkg::CODE_WRITE_LOW, sfs_pkg::CODE_WRITE_HIGH,
		sfs_pkg::CODE_ERASE_LOW, sfs_pkg::CODE_ERASE_HIGH};
	int n_mismatch = 0, samples_checked = 0;
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	sfs_regs sfs_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .program_timeout_i(program_timeout_i),
		.eeprom_write_unlock_i(eeprom_write_unlock_i), .fast_clock_select_i(fast_clock_select_i),
		.flash_write_enable_o(flash_write_enable_o), .timer2_reload_o(t2_reload), .timer2_count_o(t2_count),
		.extra_accumulator_two_o(ea2), .extra_accumulator_three_o(ea3), .processor_status_word_o(sw_out),
		.pwm_duty_o(pwm_duty_o), .slow_rc_osc_en_o(slow_rc_osc_en_o),
		.slow_crystal_osc_en_o(slow_crystal_osc_en_o), .irq_o(irq_o));
	function automatic logic [9:0] ad(input logic [7:0] i);
		return {i, 2'b00};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One classic cycle; ack and data are sampled at the edge, before it updates them
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 16) begin
			n_mismatch++;
			results();
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic pulse;
		program_timeout_i <= 1'b1;
		@(posedge clk_i);
		program_timeout_i <= 1'b0;
		settle;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values; each duty high is read before its low
		for (int i = 0; i < 13; i++) begin
			bus(0, ad(8'(sfs_pkg::IDX_T2_RELOAD_LO + i)), 8'h00);
			chk("reset value", rd, (i > 6 && i % 2 == 1) ? 8'h80 : 8'h00);
		end
		chk("reset duty", pwm_duty_o, 48'h800080008000);
		chk("reset rc", slow_rc_osc_en_o, 1'b1);
		// Complementary patterns toggle every status word bit too
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 7; i++) begin
				bus(1, ad(8'(sfs_pkg::IDX_T2_RELOAD_LO + i)), p ? 8'hAA : 8'h55);
				bus(0, ad(8'(sfs_pkg::IDX_T2_RELOAD_LO + i)), 8'h00);
				chk("byte reg", rd, p ? 8'hAA : 8'h55);
			end
		end
		settle;
		chk("reload", t2_reload, 16'hAAAA);
		chk("count", t2_count, 16'hAAAA);
		chk("acc", {ea2, ea3}, 16'hAAAA);
		chk("status word", sw_out, 8'hAA);
		// Low byte waits for high; high read latches low against later writes
		for (int c = 0; c < 3; c++) begin
			bus(1, ad(8'(8'hD2 + 2 * c)), 8'(8'h10 + c));
			settle;
			chk("duty held", pwm_duty_o[16 * c +: 16], 16'h8000);
			bus(1, ad(8'(8'hD1 + 2 * c)), 8'h3C);
			settle;
			chk("duty commit", pwm_duty_o[16 * c +: 16], {8'h3C, 8'(8'h10 + c)});
			bus(0, ad(8'(8'hD1 + 2 * c)), 8'h00);
			chk("duty high", rd, 8'h3C);
			bus(1, ad(8'(8'hD2 + 2 * c)), 8'hEE);
			bus(0, ad(8'(8'hD2 + 2 * c)), 8'h00);
			chk("duty low", rd, 8'(8'h10 + c));
		end
		bus(0, 10'h000, 8'h00);
		chk("unmapped", wb_dat_o, 32'h0);
		bus(0, 10'h329, 8'h00);
		chk("misaligned", wb_dat_o, 32'h0);
		// Kind bit locked on slow clock
		fast_clock_select_i <= 1'b0;
		settle;
		bus(1, ad(sfs_pkg::IDX_CLOCK_CTRL), 8'h80);
		settle;
		chk("kind locked", slow_crystal_osc_en_o, 1'b0);
		fast_clock_select_i <= 1'b1;
		settle;
		bus(1, ad(sfs_pkg::IDX_CLOCK_CTRL), 8'h80);
		settle;
		chk("crystal", slow_crystal_osc_en_o, 1'b1);
		chk("rc", slow_rc_osc_en_o, 1'b0);
		bus(1, ad(sfs_pkg::IDX_IRQ_MASK), 8'h01);
		for (int k = 0; k < 4; k++) begin
			bus(1, ad(8'hC9), codes[k]);
			bus(0, ad(8'hC9), 8'h00);
			chk("unlock", rd, 8'h80);
		end
		chk("write en on", flash_write_enable_o, 1'b1);
		pulse;
		bus(0, ad(8'hC9), 8'h00);
		chk("timeout flag", rd, 8'hC0);
		chk("irq set", irq_o, 1'b1);
		eeprom_write_unlock_i <= 8'h00;
		settle;
		bus(0, ad(8'hC9), 8'h00);
		chk("flag clear", rd, 8'h80);
		eeprom_write_unlock_i <= 8'h01;
		pulse;
		bus(1, ad(8'hC9), 8'h00);
		bus(0, ad(8'hC9), 8'h00);
		chk("disabled", rd, 8'h00);
		chk("write en", flash_write_enable_o, 1'b0);
		// Sticky status against mask, then write-one clear
		bus(1, ad(sfs_pkg::IDX_IRQ_MASK), 8'h00);
		settle;
		chk("irq masked", irq_o, 1'b0);
		bus(1, ad(sfs_pkg::IDX_IRQ_MASK), 8'h01);
		settle;
		chk("irq sticky", irq_o, 1'b1);
		bus(0, ad(sfs_pkg::IDX_IRQ_STATUS), 8'h00);
		chk("irq status", rd, 8'h01);
		bus(1, ad(sfs_pkg::IDX_IRQ_STATUS), 8'h01);
		settle;
		chk("irq clear", irq_o, 1'b0);
		results();
	end
endmodule
bind sfs_regs sfs_regs_properties #(.ADR_W(ADR_W)) props_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_clock_select_i(fast_clock_select_i),
	.flash_write_enable_o(flash_write_enable_o), .pwm_duty_o(pwm_duty_o),
	.slow_rc_osc_en_o(slow_rc_osc_en_o), .slow_crystal_osc_en_o(slow_crystal_osc_en_o));
